// [pwm_dac_top.sv]
// AXI4-Lite register file and pin logic of the 14-bit modulator DAC
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module pwm_dac_top
  import pwm_dac_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [AXI_DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Modulator pin
  output logic pwm_pin_out,
  output logic pwm_pin_oe
);

  logic aw_held_reg;
  logic [15:0] aw_idx_reg;
  logic w_held_reg;
  logic [7:0] w_byte_reg;
  logic w_lane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [AXI_DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic wr_en;
  logic period_sel_reg;
  logic [UPPER_VALUE_W-1:0] upper_reg;
  logic [LOWER_VALUE_W-1:0] lower_reg;
  logic [7:0] port_function_reg;
  logic load_reg;
  logic [15:0] ar_idx;
  logic [AXI_DATA_W-1:0] rd_word;
  logic rd_hit;
  wave_cfg_s cfg;
  wave_stat_s stat;

  // Protection bits carry no meaning here
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  // A write without byte lane 0 reaches no register bit
  assign wr_en = do_write && w_lane0_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_idx_reg <= s_axi_awaddr[AXI_ADDR_W-1:2];
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_byte_reg <= '0;
      w_lane0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_byte_reg <= s_axi_wdata[7:0];
      w_lane0_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      case (aw_idx_reg)
        IDX_CLOCK_CONTROL, IDX_DATA_UPPER, IDX_DATA_LOWER,
        IDX_PORT_FUNCTION, IDX_STATUS: bresp_reg <= RESP_OKAY;
        default: bresp_reg <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Only the select bit is stored; reserved bits are constants
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_sel_reg <= CLOCK_CONTROL_RESET[PERIOD_SEL_BIT];
    end else if (wr_en && aw_idx_reg == IDX_CLOCK_CONTROL) begin
      period_sel_reg <= w_byte_reg[PERIOD_SEL_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lower_reg <= DATA_LOWER_RESET;
    end else if (wr_en && aw_idx_reg == IDX_DATA_LOWER) begin
      lower_reg <= w_byte_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_reg <= DATA_UPPER_RESET[UPPER_VALUE_W-1:0];
    end else if (wr_en && aw_idx_reg == IDX_DATA_UPPER) begin
      upper_reg <= w_byte_reg[UPPER_VALUE_W-1:0];
    end
  end

  // Upper write hands the combined value over; relies on lower first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= wr_en && aw_idx_reg == IDX_DATA_UPPER;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_function_reg <= PORT_FUNCTION_RESET;
    end else if (wr_en && aw_idx_reg == IDX_PORT_FUNCTION) begin
      port_function_reg <= w_byte_reg;
    end
  end

  assign ar_idx = s_axi_araddr[AXI_ADDR_W-1:2];

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (ar_idx)
      IDX_CLOCK_CONTROL: rd_word = {24'h000000, CLOCK_CONTROL_READ};
      IDX_DATA_UPPER: rd_word = {24'h000000, DATA_READ};
      IDX_DATA_LOWER: rd_word = {24'h000000, DATA_READ};
      IDX_PORT_FUNCTION: rd_word = {24'h000000, port_function_reg};
      IDX_STATUS: begin
        rd_word[VALUE_W-1:0] = stat.active_value;
        rd_word[STATUS_LEVEL_BIT] = stat.level;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign cfg.period_sel = period_sel_reg;
  assign cfg.load = load_reg;
  // Load comes a cycle after the upper write, so both bytes are settled
  assign cfg.value = {upper_reg, lower_reg};

  pwm_wave_gen u_wave (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg),
    .stat(stat)
  );

  // Pin stays low and undriven until software hands it to the modulator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_pin_out <= 1'b0;
      pwm_pin_oe <= 1'b0;
    end else begin
      pwm_pin_out <= port_function_reg[PORT_PWM_BIT] && stat.level;
      pwm_pin_oe <= port_function_reg[PORT_PWM_BIT];
    end
  end

endmodule

// [pwm_dac_pkg.sv]
// Constants, register map and carrier types of the 14-bit modulator DAC
package pwm_dac_pkg;

  // Bus geometry
  localparam int AXI_ADDR_W = 18;
  localparam int AXI_DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CLOCK_CONTROL = 16'hffcc;
  localparam logic [15:0] IDX_DATA_UPPER = 16'hffcd;
  localparam logic [15:0] IDX_DATA_LOWER = 16'hffce;
  localparam logic [15:0] IDX_PORT_FUNCTION = 16'hffec;
  localparam logic [15:0] IDX_STATUS = 16'hffd0;

  // Reset values and read-back patterns
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'hfe;
  localparam logic [7:0] CLOCK_CONTROL_READ = 8'hff;
  localparam logic [7:0] DATA_UPPER_RESET = 8'hc0;
  localparam logic [7:0] DATA_LOWER_RESET = 8'h00;
  localparam logic [7:0] DATA_READ = 8'hff;
  localparam logic [7:0] PORT_FUNCTION_RESET = 8'h00;

  // Field positions
  localparam int PERIOD_SEL_BIT = 0;
  localparam int PORT_PWM_BIT = 0;
  localparam int UPPER_VALUE_W = 6;
  localparam int LOWER_VALUE_W = 8;
  localparam int VALUE_W = UPPER_VALUE_W + LOWER_VALUE_W;
  localparam int STATUS_LEVEL_BIT = 16;

  // Waveform timing
  localparam int PERIOD_UNITS = 16384;
  localparam int PULSES = 64;
  localparam int PULSE_UNITS = PERIOD_UNITS / PULSES;
  localparam int PULSE_IDX_W = $clog2(PULSES);
  localparam int POS_W = $clog2(PULSE_UNITS);
  localparam int CNT_W = $clog2(PERIOD_UNITS);
  localparam logic [VALUE_W-1:0] FULL_HIGH_MIN = 14'h3fc0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Carrier from the register file to the waveform generator
  typedef struct packed {
    logic period_sel;
    logic load;
    logic [VALUE_W-1:0] value;
  } wave_cfg_s;

  // Carrier back from the generator
  typedef struct packed {
    logic level;
    logic [VALUE_W-1:0] active_value;
  } wave_stat_s;

endpackage

// [pwm_wave_gen.sv]
// Pulse-divided waveform generator for the 14-bit modulator
`timescale 1ns/100ps
module pwm_wave_gen
  import pwm_dac_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration and status
  input wave_cfg_s cfg,
  output wave_stat_s stat
);

  logic prescale_reg;
  logic tick;
  logic [CNT_W-1:0] cnt_reg;
  logic period_end;
  logic [VALUE_W-1:0] pending_reg;
  logic [VALUE_W-1:0] active_reg;
  logic level_reg;
  logic [PULSE_IDX_W-1:0] pulse_idx;
  logic [PULSE_IDX_W-1:0] pulse_rev;
  logic [POS_W:0] pos;
  logic [POS_W:0] base;
  logic [POS_W:0] width;
  logic extra;
  logic level_next;

  // Resolution unit is one clock or two
  assign tick = cfg.period_sel ? prescale_reg : 1'b1;
  assign period_end = tick && (cnt_reg == CNT_W'(PERIOD_UNITS - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_reg <= 1'b0;
    end else begin
      prescale_reg <= ~prescale_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // Pending value waits for the period boundary so no period mixes data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_reg <= '0;
    end else if (cfg.load) begin
      pending_reg <= cfg.value;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_reg <= '0;
    end else if (period_end) begin
      active_reg <= cfg.load ? cfg.value : pending_reg;
    end
  end

  // Bit-reversed pulse index spreads the leftover units evenly
  assign pulse_idx = cnt_reg[CNT_W-1:POS_W];
  genvar i;
  generate
    for (i = 0; i < PULSE_IDX_W; i++) begin : g_rev
      assign pulse_rev[i] = pulse_idx[PULSE_IDX_W-1-i];
    end
  endgenerate

  // High units per pulse: value/64 + 1, plus one where the bit-reversed index is below value%64
  assign pos = {1'b0, cnt_reg[POS_W-1:0]};
  assign base = {1'b0, active_reg[VALUE_W-1:PULSE_IDX_W]} +
    (POS_W+1)'(1);
  assign extra = pulse_rev < active_reg[PULSE_IDX_W-1:0];
  assign width = base + {{POS_W{1'b0}}, extra};

  always_comb begin
    level_next = pos < width;
    if (active_reg >= FULL_HIGH_MIN) begin
      level_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
    end
  end

  assign stat.level = level_reg;
  assign stat.active_value = active_reg;

endmodule

// [pwm_dac_checker.sv]
// Assertion checker for the modulator DAC bus and pin
`timescale 1ns/100ps
module pwm_dac_checker
  import pwm_dac_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Pin
  input wire logic pwm_pin_out,
  input wire logic pwm_pin_oe
);
  logic ar_go, wr_go, ar_map, aw_map;
  logic [15:0] ar_idx, aw_idx;
  assign ar_go = s_axi_arvalid && s_axi_arready;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                 s_axi_wready;
  assign ar_idx = s_axi_araddr[17:2];
  assign aw_idx = s_axi_awaddr[17:2];
  assign ar_map = ar_idx inside {IDX_CLOCK_CONTROL, IDX_DATA_UPPER,
    IDX_DATA_LOWER, IDX_PORT_FUNCTION, IDX_STATUS};
  assign aw_map = aw_idx inside {IDX_CLOCK_CONTROL, IDX_DATA_UPPER,
    IDX_DATA_LOWER, IDX_PORT_FUNCTION, IDX_STATUS};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pin_gated: assert property (!pwm_pin_oe |-> !pwm_pin_out)
    else $error("pin high while not selected");
  a_ctrl_reads_one: assert property (ar_go &&
    ar_idx == IDX_CLOCK_CONTROL
    |=> s_axi_rvalid && s_axi_rdata == 32'h000000ff)
    else $error("control read not all ones");
  a_data_reads_one: assert property (ar_go &&
    (ar_idx == IDX_DATA_UPPER || ar_idx == IDX_DATA_LOWER)
    |=> s_axi_rvalid && s_axi_rdata == 32'h000000ff)
    else $error("data read not all ones");
  a_unmapped_read: assert property (ar_go && !ar_map
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");
  a_write_answer: assert property (wr_go |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_unmapped_write: assert property (wr_go && !aw_map
    |-> ##2 s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_write_block: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
endmodule

bind pwm_dac_top pwm_dac_checker u_chk (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .pwm_pin_out, .pwm_pin_oe);

// [lpf_model.sv]
// Low-pass filter stand-in that integrates pin high time
`timescale 1ns/100ps
module lpf_model (
  // Clock and control
  input wire logic aclk,
  input wire logic clr,
  // Pin
  input wire logic pin_out,
  input wire logic pin_oe,
  // High time in clocks
  output logic [31:0] high_cnt
);
  // Undriven pin is pulled low, so only a driven high charges the filter
  always_ff @(posedge aclk) begin
    if (clr) begin
      high_cnt <= '0;
    end else if (pin_oe && pin_out) begin
      high_cnt <= high_cnt + 1;
    end
  end
endmodule

// [pwm_14bit_dac_modulator_tb.sv]
// Self-checking bench for the modulator DAC
`timescale 1ns/100ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module pwm_14bit_dac_modulator_tb import pwm_dac_pkg::*;;
  typedef struct {logic wr; logic [15:0] idx; logic [7:0] v;
    logic [31:0] e; logic [1:0] rs;} row_s;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic clr = 0, awready, wready, bvalid, arready, rvalid, pin, oe;
  logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d, h, hc;
  logic [1:0] bresp, rresp, resp;
  int error_cnt = 0, checked = 0;
  row_s rows[9] = '{'{0, IDX_CLOCK_CONTROL, 0, 32'hff, RESP_OKAY},
    '{1, IDX_CLOCK_CONTROL, 0, 0, RESP_OKAY},
    '{0, IDX_CLOCK_CONTROL, 0, 32'hff, RESP_OKAY},
    '{0, IDX_DATA_LOWER, 0, 32'hff, RESP_OKAY},
    '{0, IDX_DATA_UPPER, 0, 32'hff, RESP_OKAY},
    '{0, 16'h0100, 0, 0, RESP_SLVERR},
    '{1, 16'h0100, 8'h5a, 0, RESP_SLVERR},
    '{1, IDX_PORT_FUNCTION, 8'h01, 0, RESP_OKAY},
    '{0, IDX_PORT_FUNCTION, 0, 32'h1, RESP_OKAY}};
  pwm_dac_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .pwm_pin_out(pin), .pwm_pin_oe(oe));
  lpf_model u_lpf (.aclk(aclk), .clr(clr), .pin_out(pin), .pin_oe(oe),
    .high_cnt(hc));
  initial begin
    forever #2 aclk = ~aclk;
  end
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tmo;
    error_cnt++;
    $display("[FAIL] wait expected answer seen none");
    final_report();
  endtask
  // Valid and payload held until the edge that takes them
  task automatic axw(input logic [15:0] idx, input logic [7:0] v);
    int n;
    logic ta, tw;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      if (bvalid) break;
      ta = awready;
      tw = wready;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end
    if (n == 50) tmo();
    resp = bresp;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [15:0] idx);
    int n;
    logic ta;
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      if (rvalid) break;
      ta = arready;
      @(posedge aclk);
      if (ta) arvalid <= 0;
    end
    if (n == 50) tmo();
    d = rdata;
    resp = rresp;
    @(posedge aclk);
  endtask
  // Polls until the generator runs the value, then lets the pin settle
  task automatic adopt(input logic [13:0] v);
    int n;
    for (n = 0; n < 20000; n++) begin
      axr(IDX_STATUS);
      if (d[13:0] === v) break;
    end
    if (n == 20000) tmo();
    repeat (4) @(posedge aclk);
  endtask
  // A periodic wave gives the same sum over any full-period window
  task automatic measure(input int p);
    clr <= 1;
    @(posedge aclk);
    clr <= 0;
    repeat (p) @(posedge aclk);
    @(negedge aclk);
    h = hc;
    @(posedge aclk);
  endtask
  initial begin
    repeat (95000) @(posedge aclk);
    tmo();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    axr(IDX_STATUS);
    `CHK("value", 14'h0, d[13:0])
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axw(rows[i].idx, rows[i].v);
      end else begin
        axr(rows[i].idx);
        `CHK("rdata", rows[i].e, d)
      end
      `CHK("resp", rows[i].rs, resp)
    end
    $display("register table done");
    // Reset value needs no adoption wait, which keeps the run short
    axw(IDX_DATA_LOWER, 8'hc0);
    measure(16384);
    `CHK("high", 32'd64, h)
    axr(IDX_STATUS);
    `CHK("value", 14'h0, d[13:0])
    $display("zero value done");
    axw(IDX_DATA_UPPER, 8'h3f);
    adopt(14'h3fc0);
    measure(2000);
    `CHK("high", 32'd2000, h)
    $display("full high done");
    axw(IDX_DATA_LOWER, 8'h34);
    axw(IDX_DATA_UPPER, 8'h12);
    adopt(14'h1234);
    // Select acts at once, so the window below is all slow periods
    axw(IDX_CLOCK_CONTROL, 8'h01);
    measure(32768);
    `CHK("high", (32'h1234 + 64) * 2, h)
    $display("slow period done");
    aresetn <= 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    `CHK("oe", 1'b0, oe)
    @(posedge aclk);
    axr(IDX_STATUS);
    `CHK("value", 14'h0, d[13:0])
    measure(300);
    `CHK("high", 32'd0, h)
    $display("second reset done");
    final_report();
  end
endmodule
